/* File: hdl/sfsf_consts.svh */
// constants for the serial flash front end
// assumes inclusion by bare name from the package and the design
`ifndef SFSF_CONSTS_SVH
`define SFSF_CONSTS_SVH
`define SFSF_MCLK_MHZ 100
`define SFSF_SCK_MAX_MHZ 66
`define SFSF_BYTE_BITS 8
`define SFSF_BIT_MSB 3'h7
`define SFSF_BIT_ZERO 3'h0
`define SFSF_PAGE_BYTES 256
`define SFSF_SECTORS 16
`define SFSF_SEC_W 4
`define SFSF_IDX_W 9
`define SFSF_IDX_ZERO 9'h000
`define SFSF_IDX_ONE 9'h001
`endif

/* File: hdl/sfsf_front_end.sv */
// serial flash front end: spi slave framing, shifting and sector protection
// assumes a command layer beside it that decodes opcodes, runs the array
// and reports busy and verify failures; all pins are asynchronous to i_mclk
// Operation
// - deselect enters standby, never deep power-down
// - output undriven while deselected
// - input ignored while deselected
// - chip select fall starts new command
// - chip select rise ends the sequence
// - standby waits for self-timed cycle end
// - input sampled on serial clock rise
// - output changes only on serial clock fall, or clears to zero at chip select fall
// - both idle clock levels work
// - all host data enters on serial input
// - serial clock up to 16 MHz: 100 MHz i_mclk over 2 * SYNC_STAGES + 2 clocks
// - program one to 256 bytes
// - erase 4K, 32K, 64K blocks, whole array
// - sixteen independently protected 64K sectors
// - global protect and unprotect of all sectors
// - verify failures readable by host
// - identification read returns maker and device
// - pause ignores clock, input; output undriven
// - lock input active low, pulled high
`timescale 1ns/1ps
`include "sfsf_consts.svh"
`default_nettype none
module sfsf_front_end #(
    parameter int SYNC_STAGES = 2 // flip-flops per pin synchroniser
) (
    input wire logic i_mclk, // system clock, 100 MHz
    input wire logic i_reset_n, // synchronous reset, active low
    input wire logic i_cs_n, // chip select pin, active low
    input wire logic i_sck, // serial clock pin
    input wire logic i_si, // serial input pin
    input wire logic i_pause_n, // pause pin, active low
    input wire logic i_lock_n, // hardware lock pin, active low
    output logic o_so, // serial output value
    output logic o_so_oe, // serial output enable, high drives
    input wire logic i_tx_en, // command layer wants read data driven
    input wire sfsf_pkg::sfsf_byte_t i_tx_data, // next byte to shift out
    output logic o_tx_req, // pulse: supply next tx byte
    output logic o_frame_start, // pulse: frame opened
    output logic o_frame_end, // pulse: frame closed after a whole opcode
    output logic o_op_valid, // pulse: opcode byte received
    output sfsf_pkg::sfsf_byte_t o_op_code, // last opcode
    output logic o_byte_valid, // pulse: address or data byte received
    output sfsf_pkg::sfsf_byte_t o_byte_data, // last address or data byte
    output sfsf_pkg::sfsf_idx_t o_byte_index, // bytes after opcode, saturating
    input wire logic i_busy, // self-timed program or erase running
    output logic o_standby, // device in standby
    input wire logic i_fail_set, // pulse: verify failure of last operation
    input wire logic i_fail_clr, // pulse: host cleared the failure flag
    output logic o_fail, // sticky verify failure
    input wire logic i_prot_set, // pulse: protect one sector
    input wire logic i_prot_clr, // pulse: unprotect one sector
    input wire sfsf_pkg::sfsf_sec_t i_prot_sec, // sector for set or clear
    input wire logic i_prot_all_set, // pulse: protect every sector
    input wire logic i_prot_all_clr, // pulse: unprotect every sector
    output sfsf_pkg::sfsf_prot_t o_prot, // protection bits per sector
    output logic o_locked // protection changes refused
);
    import sfsf_pkg::*;

    // oversampling needs a few system clocks per serial phase; a true 66 MHz
    // link needs a faster i_mclk, so the rate here is an elaboration check
    localparam int SCK_MIN_MCLK = 2 * SYNC_STAGES + 2; // cycles per sck period
    localparam int SCK_CAP_MHZ = `SFSF_MCLK_MHZ / SCK_MIN_MCLK; // served rate
    // refuse a synchroniser too short to be safe, or a link rate of nothing
    if (SYNC_STAGES < 2 || SCK_CAP_MHZ < 1) begin : g_bad_params
        $error("sfsf_front_end: at least two sync stages needed");
    end

    // pin synchronisers: first stage feeds only the next stage
    logic [SYNC_STAGES-1:0] cs_sync_reg;
    logic [SYNC_STAGES-1:0] sck_sync_reg;
    logic [SYNC_STAGES-1:0] si_sync_reg;
    logic [SYNC_STAGES-1:0] pause_sync_reg;
    logic [SYNC_STAGES-1:0] lock_sync_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cs_sync_reg <= '1; // deselected
            sck_sync_reg <= '0;
            si_sync_reg <= '0;
            pause_sync_reg <= '1; // not paused
            lock_sync_reg <= '1; // pulled high: unlocked
        end else begin
            cs_sync_reg <= {cs_sync_reg[SYNC_STAGES-2:0], i_cs_n};
            sck_sync_reg <= {sck_sync_reg[SYNC_STAGES-2:0], i_sck};
            si_sync_reg <= {si_sync_reg[SYNC_STAGES-2:0], i_si};
            pause_sync_reg <= {pause_sync_reg[SYNC_STAGES-2:0], i_pause_n};
            lock_sync_reg <= {lock_sync_reg[SYNC_STAGES-2:0], i_lock_n};
        end
    end
    logic cs_n_s; // synchronised chip select
    logic sck_s; // synchronised serial clock
    logic si_s; // synchronised serial input
    logic pause_n_s; // synchronised pause
    assign cs_n_s = cs_sync_reg[SYNC_STAGES-1];
    assign sck_s = sck_sync_reg[SYNC_STAGES-1];
    assign si_s = si_sync_reg[SYNC_STAGES-1];
    assign pause_n_s = pause_sync_reg[SYNC_STAGES-1];

    // edge history on synchronised levels
    logic cs_n_d_reg; // chip select one cycle back
    logic sck_d_reg; // serial clock one cycle back
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cs_n_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sck_d_reg <= sck_s;
        end
    end
    logic cs_fall; // frame opens
    logic cs_rise; // frame closes
    logic active; // selected and not paused
    logic sck_rise; // qualified rising edge
    logic sck_fall; // qualified falling edge
    assign cs_fall = cs_n_d_reg && !cs_n_s;
    assign cs_rise = !cs_n_d_reg && cs_n_s;
    assign active = !cs_n_s && pause_n_s;
    // idle level is never looked at, only edges, so mode 0 and 3 both work
    assign sck_rise = active && !sck_d_reg && sck_s;
    assign sck_fall = active && sck_d_reg && !sck_s;

    // frame state machine
    sfsf_state_t state_reg;
    sfsf_state_t state_next;
    logic [2:0] bit_cnt_reg; // bit position within the current byte
    logic byte_done; // eighth bit arrives now
    assign byte_done = sck_rise && (bit_cnt_reg == `SFSF_BIT_MSB);
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SFSF_ST_STANDBY: begin
                if (cs_fall) begin
                    state_next = SFSF_ST_CMD;
                end
            end
            SFSF_ST_CMD: begin
                if (cs_rise) begin
                    state_next = i_busy ? SFSF_ST_WAIT : SFSF_ST_STANDBY;
                end else if (byte_done) begin
                    state_next = SFSF_ST_DATA;
                end
            end
            SFSF_ST_DATA: begin
                if (cs_rise) begin
                    state_next = i_busy ? SFSF_ST_WAIT : SFSF_ST_STANDBY;
                end
            end
            SFSF_ST_WAIT: begin
                // self-timed cycle still running; a new frame may still open
                if (cs_fall) begin
                    state_next = SFSF_ST_CMD;
                end else if (!i_busy) begin
                    state_next = SFSF_ST_STANDBY;
                end
            end
            default: begin
                state_next = SFSF_ST_STANDBY;
            end
        endcase
    end
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg <= SFSF_ST_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end
    // standby is only ever standby; deep power-down is not reachable here
    assign o_standby = (state_reg == SFSF_ST_STANDBY);

    // receive shifter: msb first, every byte on serial input only
    sfsf_byte_t rx_sh_reg; // bits collected so far
    sfsf_byte_t rx_byte; // byte completed this cycle
    assign rx_byte = {rx_sh_reg[`SFSF_BYTE_BITS-2:0], si_s};
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || cs_fall) begin
            bit_cnt_reg <= `SFSF_BIT_ZERO; // fresh count per frame
            rx_sh_reg <= '0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg <= rx_byte;
        end
    end

    // received byte reporting
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_op_valid <= 1'b0;
            o_byte_valid <= 1'b0;
            o_op_code <= '0;
            o_byte_data <= '0;
            o_byte_index <= `SFSF_IDX_ZERO;
        end else begin
            o_op_valid <= byte_done && (state_reg == SFSF_ST_CMD);
            o_byte_valid <= byte_done && (state_reg == SFSF_ST_DATA);
            if (cs_fall) begin
                o_byte_index <= `SFSF_IDX_ZERO;
            end else if (byte_done && (state_reg == SFSF_ST_CMD)) begin
                o_op_code <= rx_byte;
            end else if (byte_done && (state_reg == SFSF_ST_DATA)) begin
                o_byte_data <= rx_byte;
                // saturates so long page programs never wrap the count
                if (o_byte_index != '1) begin
                    o_byte_index <= o_byte_index + `SFSF_IDX_ONE;
                end
            end
        end
    end

    // frame pulses for the command layer
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_frame_start <= 1'b0;
            o_frame_end <= 1'b0;
        end else begin
            o_frame_start <= cs_fall;
            o_frame_end <= cs_rise && (state_reg == SFSF_ST_DATA);
        end
    end

    // transmit shifter: new bit only on a falling serial clock edge
    sfsf_byte_t tx_sh_reg; // remaining bits of the byte in flight
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || cs_fall) begin
            o_so <= 1'b0;
            tx_sh_reg <= '0;
        end else if (sck_fall) begin
            if (bit_cnt_reg == `SFSF_BIT_ZERO) begin
                o_so <= i_tx_data[`SFSF_BYTE_BITS-1];
                tx_sh_reg <= {i_tx_data[`SFSF_BYTE_BITS-2:0], 1'b0};
            end else begin
                o_so <= tx_sh_reg[`SFSF_BYTE_BITS-1];
                tx_sh_reg <= {tx_sh_reg[`SFSF_BYTE_BITS-2:0], 1'b0};
            end
        end
    end
    // request the next byte as soon as a byte boundary passes
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_tx_req <= 1'b0;
        end else begin
            o_tx_req <= byte_done || cs_fall;
        end
    end
    // pin driven only while selected, not paused and reading
    assign o_so_oe = active && i_tx_en && !o_standby;

    // sector protection; lock pin freezes the bits against changes
    logic lock_n_s; // synchronised lock pin
    assign lock_n_s = lock_sync_reg[SYNC_STAGES-1];
    assign o_locked = !lock_n_s;
    wire sfsf_prot_t prot_next; // per-sector next value; all-sector pulses win
    genvar g;
    generate
        for (g = 0; g < `SFSF_SECTORS; g = g + 1) begin : g_prot
            assign prot_next[g] = i_prot_all_set ? 1'b1 :
                i_prot_all_clr ? 1'b0 :
                (i_prot_set && (i_prot_sec == sfsf_sec_t'(g))) ? 1'b1 :
                (i_prot_clr && (i_prot_sec == sfsf_sec_t'(g))) ? 1'b0 : o_prot[g];
        end
    endgenerate
    // one register for all sectors, so a single process owns every bit
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_prot <= '1; // protected out of reset
        end else if (lock_n_s) begin
            o_prot <= prot_next;
        end
    end

    // sticky verify failure: a set in the clear cycle wins
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_fail <= 1'b0;
        end else if (i_fail_set) begin
            o_fail <= 1'b1;
        end else if (i_fail_clr) begin
            o_fail <= 1'b0;
        end
    end

    // checks
    chk_oe_deselect: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        cs_n_s |-> !o_so_oe) else $error("output driven while deselected");
    chk_oe_pause: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !pause_n_s |-> !o_so_oe) else $error("output driven while paused");
    chk_no_capture: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        cs_n_s |=> $stable(rx_sh_reg)) else $error("bit taken while deselected");
    chk_so_on_fall: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $changed(o_so) |-> $past(sck_fall) || $past(cs_fall))
        else $error("output changed off a falling edge");
    chk_cmd_start: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        cs_fall |=> state_reg == SFSF_ST_CMD && bit_cnt_reg == `SFSF_BIT_ZERO)
        else $error("frame did not open");
    chk_wait_busy: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        cs_rise && i_busy && !o_standby |=> !o_standby)
        else $error("standby entered while busy");
    chk_standby_idle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_reg == SFSF_ST_WAIT && !i_busy && !cs_fall |=> o_standby)
        else $error("standby not entered after cycle");
    chk_opcode_shift: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        byte_done && state_reg == SFSF_ST_CMD |=> o_op_valid && o_op_code == $past(rx_byte))
        else $error("opcode not reported");
    chk_partial_drop: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        cs_rise && state_reg == SFSF_ST_CMD |=> !o_op_valid && !o_frame_end)
        else $error("partial opcode acted on");
    chk_fail_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_fail_set |=> o_fail) else $error("failure flag lost");
    chk_lock_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_locked |=> $stable(o_prot)) else $error("protection changed while locked");
endmodule // sfsf_front_end
`default_nettype wire

/* File: hdl/sfsf_pkg.sv */
// types for the serial flash front end
// assumes sfsf_consts.svh on the include path
`default_nettype none
`include "sfsf_consts.svh"
package sfsf_pkg;
    // one-hot frame states
    typedef enum logic [3:0] {
        SFSF_ST_STANDBY = 4'h1,
        SFSF_ST_CMD = 4'h2,
        SFSF_ST_DATA = 4'h4,
        SFSF_ST_WAIT = 4'h8
    } sfsf_state_t;
    typedef logic [`SFSF_BYTE_BITS-1:0] sfsf_byte_t;
    typedef logic [`SFSF_SECTORS-1:0] sfsf_prot_t;
    typedef logic [`SFSF_SEC_W-1:0] sfsf_sec_t;
    typedef logic [`SFSF_IDX_W-1:0] sfsf_idx_t;
endpackage
`default_nettype wire

/* File: test/sfsf_front_end_bench.sv */
// self-checking bench for the serial flash front end
// assumes sfsf_host_model drives the spi and pause pins; lock pin and command-layer inputs driven here
`timescale 1ns/1ps
`default_nettype none
module sfsf_front_end_bench;
    import sfsf_pkg::*;
    logic i_mclk = 1'b0; // system clock
    logic i_reset_n = 1'b0; // synchronous reset, active low
    logic i_lock_n = 1'b1; // lock pin, released
    logic i_tx_en = 1'b0; // read frame enable
    logic i_busy = 1'b0; // self-timed cycle running
    logic i_prot_all_set = 1'b0, i_prot_all_clr = 1'b0; // whole-array protection pulses
    logic i_prot_set = 1'b0, i_prot_clr = 1'b0; // single-sector protection pulses
    logic i_fail_set = 1'b0, i_fail_clr = 1'b0; // verify failure pulses
    sfsf_byte_t i_tx_data = 8'h96; // byte shifted out on reads
    sfsf_sec_t i_prot_sec = 4'h0; // sector for single changes
    wire logic cs_n, sck, si, pause_n, so, so_oe, tx_req, f_st, f_end, op_v, b_v, sby, fail;
    wire logic locked; // hardware lock seen
    sfsf_byte_t op_code, b_data;
    sfsf_idx_t b_idx;
    sfsf_prot_t prot;
    int bad_count = 0; // mismatches
    int comparisons = 0; // checks made
    int fs_cnt = 0, fe_cnt = 0, op_cnt = 0, bv_cnt = 0, cs_hi = 0, pz = 0;
    int tr_cnt = 0; // next-byte requests seen
    logic [7:0] r; // byte read back by the host
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    sfsf_front_end sfsf_front_end_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_pause_n(pause_n), .i_lock_n(i_lock_n),
        .o_so(so), .o_so_oe(so_oe), .i_tx_en(i_tx_en), .i_tx_data(i_tx_data),
        .o_tx_req(tx_req), .o_frame_start(f_st), .o_frame_end(f_end), .o_op_valid(op_v),
        .o_op_code(op_code), .o_byte_valid(b_v), .o_byte_data(b_data), .o_byte_index(b_idx),
        .i_busy(i_busy), .o_standby(sby), .i_fail_set(i_fail_set), .i_fail_clr(i_fail_clr),
        .o_fail(fail), .i_prot_set(i_prot_set), .i_prot_clr(i_prot_clr),
        .i_prot_sec(i_prot_sec), .i_prot_all_set(i_prot_all_set),
        .i_prot_all_clr(i_prot_all_clr), .o_prot(prot), .o_locked(locked));
    sfsf_host_model sfsf_host_model_inst (.i_mclk(i_mclk), .i_so(so), .i_so_oe(so_oe),
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_pause_n(pause_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // pulse counters, and the output enable watched once the pins have synced
    always @(posedge i_mclk) begin
        fs_cnt += (f_st === 1'b1);
        fe_cnt += (f_end === 1'b1);
        op_cnt += (op_v === 1'b1);
        bv_cnt += (b_v === 1'b1);
        tr_cnt += (tx_req === 1'b1);
        cs_hi = cs_n ? cs_hi + 1 : 0;
        pz = pause_n ? 0 : pz + 1;
        if ((cs_hi > 4 || pz > 4) && so_oe !== 1'b0) begin
            chk(so_oe, 1'b0, "so driven while deselected or paused");
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic pulse(input logic [5:0] v, input sfsf_sec_t s, input logic [15:0] exp);
        @(negedge i_mclk);
        {i_prot_all_set, i_prot_all_clr, i_prot_set, i_prot_clr, i_fail_set, i_fail_clr} = v;
        i_prot_sec = s;
        @(negedge i_mclk);
        {i_prot_all_set, i_prot_all_clr, i_prot_set, i_prot_clr, i_fail_set, i_fail_clr} = 6'h00;
        chk({prot[15:1], prot[0] ^ fail}, exp, "protection or fail flag");
    endtask
    // opcode plus two bytes in mode 3
    task automatic t_frame();
        sfsf_host_model_inst.start(1'b1);
        sfsf_host_model_inst.xbits(8'ha5, 8, r);
        sfsf_host_model_inst.xbits(8'h3c, 8, r);
        sfsf_host_model_inst.xbits(8'h81, 8, r);
        sfsf_host_model_inst.stop();
        chk({op_code, b_data}, 16'ha581, "opcode and data");
        chk({7'h00, b_idx}, 16'h0002, "byte index");
        chk({fs_cnt[3:0], fe_cnt[3:0], op_cnt[3:0], bv_cnt[3:0]}, 16'h1112, "frame pulses");
        chk(tr_cnt[15:0], 16'h0004, "next byte requests");
        chk(sby, 1'b1, "standby after deselect");
    endtask
    // partial opcode, then activity while deselected: nothing taken
    task automatic t_partial();
        sfsf_host_model_inst.start(1'b0);
        sfsf_host_model_inst.xbits(8'hff, 5, r);
        sfsf_host_model_inst.stop();
        sfsf_host_model_inst.noise(16);
        chk({fe_cnt[7:0], op_cnt[7:0]}, 16'h0101, "partial opcode taken");
        chk({fs_cnt[7:0], bv_cnt[7:0]}, 16'h0202, "deselected bits taken");
    endtask
    // read in mode 0 with a pause in mid-opcode
    task automatic t_read();
        i_tx_en = 1'b1;
        sfsf_host_model_inst.start(1'b0);
        sfsf_host_model_inst.xbits(8'hc3, 4, r);
        sfsf_host_model_inst.hold(3);
        sfsf_host_model_inst.xbits(8'h30, 4, r);
        sfsf_host_model_inst.xbits(8'h00, 8, r);
        chk({op_code, r}, 16'hc396, "paused opcode and read byte");
        // the request for the next byte has passed, so the new byte is taken at the next fall
        i_tx_data = 8'h3c;
        sfsf_host_model_inst.xbits(8'h00, 8, r);
        sfsf_host_model_inst.stop();
        i_tx_en = 1'b0;
        chk({8'h00, r}, 16'h003c, "second read byte");
    endtask
    // deselect during a self-timed cycle holds off standby
    task automatic t_busy();
        int n;
        i_busy = 1'b1;
        sfsf_host_model_inst.start(1'b0);
        sfsf_host_model_inst.xbits(8'h20, 8, r);
        sfsf_host_model_inst.stop();
        chk(sby, 1'b0, "standby while busy");
        i_busy = 1'b0;
        n = 0;
        while (sby !== 1'b1 && n < 20) begin
            @(negedge i_mclk);
            n++;
        end
        chk(sby, 1'b1, "standby after busy");
        if (sby !== 1'b1) begin
            close_out();
        end
    endtask
    initial begin
        repeat (3) @(negedge i_mclk);
        i_reset_n = 1'b1;
        chk({sby, so_oe, fail, locked}, 4'h8, "reset state");
        chk(prot, 16'hffff, "reset protection");
        t_frame();
        t_partial();
        t_read();
        t_busy();
        pulse(6'h10, 4'h0, 16'h0000);
        pulse(6'h08, 4'h5, 16'h0020);
        pulse(6'h04, 4'h5, 16'h0000);
        pulse(6'h20, 4'h0, 16'hffff);
        pulse(6'h12, 4'h0, 16'h0001);
        pulse(6'h03, 4'h0, 16'h0001);
        pulse(6'h01, 4'h0, 16'h0000);
        i_lock_n = 1'b0;
        repeat (6) @(negedge i_mclk);
        chk(locked, 1'b1, "lock seen");
        pulse(6'h20, 4'h0, 16'h0000);
        i_lock_n = 1'b1;
        repeat (6) @(negedge i_mclk);
        pulse(6'h20, 4'h0, 16'hffff);
        close_out();
    end
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
endmodule // sfsf_front_end_bench
`default_nettype wire

/* File: test/sfsf_host_model.sv */
// spi host model standing on the far side of the serial flash front end
// assumes it is paced by i_mclk falling edges; sck half period is 4 clocks
`timescale 1ns/1ps
`default_nettype none
module sfsf_host_model (
    input wire logic i_mclk, // system clock, used for pacing and to register so_last
    input wire logic i_so, // device output value
    input wire logic i_so_oe, // device output enable
    output logic o_cs_n, // chip select, active low
    output logic o_sck, // serial clock
    output logic o_si, // serial data to the device
    output logic o_pause_n // pause, active low
);
    logic mode3; // clock idles high when set
    logic so_last = 1'b0; // last level the device drove
    wire logic so_line; // wire level as the host sees it
    // a released line shows the inverse of its last level, never a stale copy
    always @(posedge i_mclk) begin
        if (i_so_oe) begin
            so_last <= i_so;
        end
    end
    assign so_line = i_so_oe ? i_so : ~so_last;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_pause_n = 1'b1;
        mode3 = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge i_mclk);
    endtask
    // open a frame with the clock parked at the mode's idle level
    task automatic start(input logic m3);
        mode3 = m3;
        o_sck = m3;
        half();
        o_cs_n = 1'b0;
        half();
    endtask
    // n bits msb first; si moves in the low phase, so is read late in the high phase
    task automatic xbits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            o_sck = 1'b0;
            o_si = b[7-i];
            half();
            o_sck = 1'b1;
            repeat (3) @(negedge i_mclk);
            r = {r[6:0], so_line};
            @(negedge i_mclk);
        end
    endtask
    // close the frame and give the synchronisers time to settle
    task automatic stop();
        if (!mode3) begin
            o_sck = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        repeat (10) @(negedge i_mclk);
    endtask
    // pause with the clock low, then wiggle clock and data n times
    task automatic hold(input int n);
        o_sck = 1'b0;
        half();
        o_pause_n = 1'b0;
        for (int i = 0; i < 2 * n; i++) begin
            half();
            o_sck = ~o_sck;
            o_si = ~o_si;
        end
        half();
        o_pause_n = 1'b1;
        half();
    endtask
    // clock and data activity while deselected
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            o_sck = ~o_sck;
            o_si = ~o_si;
            half();
        end
        o_sck = 1'b0;
    endtask
endmodule // sfsf_host_model
`default_nettype wire
